// >>> core/fapes_defines.vh
/*
 holds: timing counts, status bit positions and command codes for the
 flash program/erase host controller.
 assumes: a 20 MHz system clock (50 ns period).
*/
`ifndef FAPES_DEFINES_VH
`define FAPES_DEFINES_VH

// ****************************************************
// clock and times
// ****************************************************
`define FAPES_CLK_NS          50
`define FAPES_PROG_MAX_US     210
`define FAPES_SECT_MAX_MS     10400
`define FAPES_CHIP_MAX_MS     32000
`define FAPES_LOAD_WIN_US     100
`define FAPES_PROT_PW_US      10
`define FAPES_UNPROT_PW_MS    12
`define FAPES_OE_LEAD_US      4
`define FAPES_CMD_PW_NS       100
// cycle counts (least times rounded up except the unprotect pulse, which is rounded down like the longest times)
`define FAPES_PROG_CYC    ((`FAPES_PROG_MAX_US*1000)/`FAPES_CLK_NS)
`define FAPES_SECT_CYC    ((`FAPES_SECT_MAX_MS*20000))
`define FAPES_CHIP_CYC    ((`FAPES_CHIP_MAX_MS*20000))
`define FAPES_LOAD_CYC    ((`FAPES_LOAD_WIN_US*1000)/`FAPES_CLK_NS)
`define FAPES_PROT_CYC    ((`FAPES_PROT_PW_US*1000+`FAPES_CLK_NS-1)/`FAPES_CLK_NS)
`define FAPES_UNPROT_CYC  ((`FAPES_UNPROT_PW_MS*1000000)/`FAPES_CLK_NS)
`define FAPES_OE_CYC      ((`FAPES_OE_LEAD_US*1000+`FAPES_CLK_NS-1)/`FAPES_CLK_NS)
`define FAPES_CMD_CYC     ((`FAPES_CMD_PW_NS+`FAPES_CLK_NS-1)/`FAPES_CLK_NS)

// ****************************************************
// status bits and operations
// ****************************************************
`define FAPES_POLL_BIT    7
`define FAPES_TOGGLE_BIT  6
`define FAPES_PROTF_BIT   0
`define FAPES_OP_PROG     3'h0
`define FAPES_OP_CHIP     3'h1
`define FAPES_OP_SECT     3'h2
`define FAPES_OP_PROT     3'h3
`define FAPES_OP_UNPROT   3'h4
`define FAPES_OP_READ     3'h5
`define FAPES_OP_IDRD     3'h6

`endif

// >>> core/fapes_bus_cycle.v
/*
 holds: one parallel bus cycle (write or read) on the flash pins.
 assumes: inputs synchronous to clk_sys; strobes held PW+1 cycles.
*/
`timescale 1ns/100ps
module fapes_bus_cycle #(
   parameter PW = 2
) (
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire        start,
   input  wire        isWrite,
   input  wire [18:0] addrIn,
   input  wire [7:0]  dataIn,
   output reg         busy,
   output reg         done,
   output reg  [7:0]  rdData_q,
   output reg  [18:0] flAddr,
   output reg  [7:0]  flDqOut,
   output reg         flDqOe,
   output reg         flCeN,
   output reg         flWeN,
   output reg         flOeN,
   input  wire [7:0]  flDqIn
);
   reg [15:0] cnt_q;

   // ****************************************************
   // strobe sequencer
   // ****************************************************
   always @(posedge clk_sys) begin
      done <= 1'b0;
      if (!nrst) begin
         busy     <= 1'b0;
         cnt_q    <= 16'h0000;
         rdData_q <= 8'h00;
         flAddr   <= 19'h00000;
         flDqOut  <= 8'h00;
         flDqOe   <= 1'b0;
         flCeN    <= 1'b1;
         flWeN    <= 1'b1;
         flOeN    <= 1'b1;
      end else if (!busy) begin
         if (start) begin
            busy    <= 1'b1;
            cnt_q   <= PW[15:0];
            flAddr  <= addrIn;
            flDqOut <= dataIn;
            flDqOe  <= isWrite;
            flCeN   <= 1'b0;
            flWeN   <= ~isWrite;
            flOeN   <= isWrite;
         end
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end else begin
         busy <= 1'b0;
         done <= 1'b1;
         if (!flOeN)
            rdData_q <= flDqIn;
         flCeN  <= 1'b1;
         flWeN  <= 1'b1;
         flOeN  <= 1'b1;
         flDqOe <= 1'b0;
      end
   end
endmodule // fapes_bus_cycle

// >>> core/fapes_host.v
/*
 holds: host controller that drives a byte-wide flash through its
 embedded program/erase algorithms and watches status bits.
 assumes: single 20 MHz clock, inputs synchronous, a tristate wrapper
 resolves the data pins from flDqOe.
*/
`timescale 1ns/100ps
`include "fapes_defines.vh"
module fapes_host #(
   parameter PROG_CYC   = `FAPES_PROG_CYC,
   parameter SECT_CYC   = `FAPES_SECT_CYC,
   parameter CHIP_CYC   = `FAPES_CHIP_CYC,
   parameter LOAD_CYC   = `FAPES_LOAD_CYC,
   parameter UNPROT_CYC = `FAPES_UNPROT_CYC,
   parameter PROT_CYC   = `FAPES_PROT_CYC,
   parameter OE_CYC     = `FAPES_OE_CYC
) (
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire        reqValid,
   output wire        reqReady,
   input  wire [2:0]  reqOp,
   input  wire [18:0] reqAddr,
   input  wire [7:0]  reqData,
   input  wire [5:0]  extraSector,
   input  wire        extraValid,
   output reg         rspValid,
   output reg         rspFail,
   output reg  [7:0]  rspData,
   output reg         protectFlag,
   output wire [18:0] flAddr,
   output wire [7:0]  flDqOut,
   output wire        flDqOe,
   input  wire [7:0]  flDqIn,
   output wire        flCeN,
   output wire        flWeN,
   output wire        flOeN,
   output reg         flOeHv,
   output reg         flA9Hv
);
   localparam ST_IDLE = 4'h0;
   localparam ST_CMD  = 4'h1;
   localparam ST_WAIT = 4'h2;
   localparam ST_LOAD = 4'h3;
   localparam ST_POLL = 4'h4;
   localparam ST_READ = 4'h5;
   localparam ST_OESU = 4'h6;
   localparam ST_WPUL = 4'h7;
   localparam ST_DONE = 4'h8;
   localparam ST_HVOF = 4'h9;

   reg [3:0]  state_q;
   reg [2:0]  op_q;
   reg [18:0] addr_q;
   reg [7:0]  data_q;
   reg [2:0]  step_q;
   reg [31:0] tmo_q;
   reg [31:0] win_q;
   reg [7:0]  last_q;
   reg        haveLast_q;
   reg        start;
   reg        isWrite;
   reg [18:0] cycAddr;
   reg [7:0]  cycData;
   reg [2:0]  nSteps;
   reg        wpLow_q;
   wire       busy;
   wire       done;
   wire [7:0] rdData;
   wire       cycWeN;

   // unlock/command sequence, one entry per write step
   function [26:0] cmdStep;
      input [2:0]  op;
      input [2:0]  idx;
      input [18:0] a;
      input [7:0]  d;
      begin
         case (idx)
            3'h0: cmdStep = {19'h00555, 8'haa};
            3'h1: cmdStep = {19'h002aa, 8'h55};
            3'h2: cmdStep = (op == `FAPES_OP_PROG) ?
                            {19'h00555, 8'ha0} :
                            (op == `FAPES_OP_IDRD) ?
                            {19'h00555, 8'h90} : {19'h00555, 8'h80};
            3'h3: cmdStep = (op == `FAPES_OP_PROG) ?
                            {a, d} : {19'h00555, 8'haa};
            3'h4: cmdStep = {19'h002aa, 8'h55};
            default: cmdStep = (op == `FAPES_OP_CHIP) ?
                            {19'h00555, 8'h10} :
                            {a[18:13], 13'h0000, 8'h30};
         endcase
      end
   endfunction

   assign reqReady = (state_q == ST_IDLE);
   assign flWeN    = cycWeN & ~wpLow_q;

   fapes_bus_cycle #(
      .PW (`FAPES_CMD_CYC)
   ) u_cyc (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .start    (start),
      .isWrite  (isWrite),
      .addrIn   (cycAddr),
      .dataIn   (cycData),
      .busy     (busy),
      .done     (done),
      .rdData_q (rdData),
      .flAddr   (flAddr),
      .flDqOut  (flDqOut),
      .flDqOe   (flDqOe),
      .flCeN    (flCeN),
      .flWeN    (cycWeN),
      .flOeN    (flOeN),
      .flDqIn   (flDqIn)
   );

   // ****************************************************
   // bus cycle requests
   // ****************************************************
   always @* begin
      nSteps = (op_q == `FAPES_OP_PROG) ? 3'h4 :
               (op_q == `FAPES_OP_IDRD) ? 3'h3 : 3'h6;
      start   = 1'b0;
      isWrite = 1'b1;
      {cycAddr, cycData} = cmdStep(op_q, step_q, addr_q, data_q);
      if (state_q == ST_CMD && !busy && !done)
         start = 1'b1;
      // no extra sector write may finish after the load window
      if (state_q == ST_LOAD && !busy && !done && extraValid &&
          win_q > 32'h00000006) begin
         start   = 1'b1;
         cycAddr = {extraSector, 13'h0000};
         cycData = 8'h30;
      end
      if ((state_q == ST_POLL || state_q == ST_READ) &&
          !busy && !done) begin
         start   = 1'b1;
         isWrite = 1'b0;
         cycAddr = (op_q == `FAPES_OP_IDRD) ? 19'h00002 : addr_q;
         cycData = 8'h00;
      end
   end

   // ****************************************************
   // operation sequencer
   // ****************************************************
   always @(posedge clk_sys) begin
      rspValid <= 1'b0;
      if (!nrst) begin
         state_q     <= ST_IDLE;
         op_q        <= 3'h0;
         addr_q      <= 19'h00000;
         data_q      <= 8'h00;
         step_q      <= 3'h0;
         tmo_q       <= 32'h00000000;
         win_q       <= 32'h00000000;
         last_q      <= 8'h00;
         haveLast_q  <= 1'b0;
         rspFail     <= 1'b0;
         rspData     <= 8'h00;
         protectFlag <= 1'b0;
         flOeHv      <= 1'b0;
         flA9Hv      <= 1'b0;
         wpLow_q     <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: if (reqValid) begin
               op_q       <= reqOp;
               addr_q     <= reqAddr;
               data_q     <= reqData;
               step_q     <= 3'h0;
               haveLast_q <= 1'b0;
               if (reqOp == `FAPES_OP_READ)
                  state_q <= ST_READ;
               else if (reqOp == `FAPES_OP_PROT ||
                        reqOp == `FAPES_OP_UNPROT) begin
                  flOeHv  <= 1'b1;
                  flA9Hv  <= 1'b1;
                  tmo_q   <= OE_CYC;
                  state_q <= ST_OESU;
               end else
                  state_q <= ST_CMD;
            end
            ST_CMD: if (done) begin
               if (step_q == nSteps - 3'h1) begin
                  if (op_q == `FAPES_OP_IDRD)
                     state_q <= ST_READ;
                  else if (op_q == `FAPES_OP_SECT) begin
                     win_q   <= LOAD_CYC;
                     state_q <= ST_LOAD;
                  end else begin
                     tmo_q   <= (op_q == `FAPES_OP_PROG) ?
                                PROG_CYC : CHIP_CYC;
                     state_q <= ST_POLL;
                  end
               end else
                  step_q <= step_q + 3'h1;
            end
            ST_LOAD: begin
               win_q <= win_q - 32'h1;
               if (win_q <= 32'h1 && !busy) begin
                  tmo_q   <= SECT_CYC;
                  state_q <= ST_POLL;
               end
            end
            ST_POLL: begin
               if (tmo_q != 32'h0)
                  tmo_q <= tmo_q - 32'h1;
               if (done) begin
                  last_q     <= rdData;
                  haveLast_q <= 1'b1;
                  // data polling; toggle as second witness
                  if ((op_q == `FAPES_OP_PROG &&
                       rdData[`FAPES_POLL_BIT] == data_q[`FAPES_POLL_BIT]) ||
                      (op_q != `FAPES_OP_PROG && rdData[`FAPES_POLL_BIT]) ||
                      (haveLast_q && rdData[`FAPES_TOGGLE_BIT] ==
                       last_q[`FAPES_TOGGLE_BIT])) begin
                     rspFail <= 1'b0; // no host verify
                     state_q <= ST_DONE;
                  end else if (tmo_q == 32'h0) begin
                     rspFail <= 1'b1;
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_READ: if (done) begin
               rspData <= rdData;
               rspFail <= 1'b0;
               if (op_q == `FAPES_OP_IDRD)
                  protectFlag <= rdData[`FAPES_PROTF_BIT];
               state_q <= ST_DONE;
            end
            ST_OESU: if (tmo_q <= 32'h1) begin
               wpLow_q <= 1'b1;
               tmo_q   <= (op_q == `FAPES_OP_PROT) ?
                          PROT_CYC : UNPROT_CYC;
               state_q <= ST_WPUL;
            end else
               tmo_q <= tmo_q - 32'h1;
            ST_WPUL: if (tmo_q <= 32'h1) begin
               wpLow_q <= 1'b0;
               state_q <= ST_HVOF;
            end else
               tmo_q <= tmo_q - 32'h1;
            ST_HVOF: begin
               // high voltage outlasts the write pulse edge
               flOeHv  <= 1'b0;
               flA9Hv  <= 1'b0;
               rspFail <= 1'b0;
               state_q <= ST_DONE;
            end
            ST_DONE: begin
               rspValid <= 1'b1;
               state_q  <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // fapes_host

// >>> sim/fapes_host_asserts.sv
/* checker on the host controller ports.
 assumes: bound into fapes_host, one clock. */
`timescale 1ns/100ps
`include "fapes_defines.vh"
module fapes_host_asserts #(
   parameter PROG_CYC = 4200,
   parameter PROT_CYC = 200,
   parameter OE_CYC   = 80
) (
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       reqValid,
   input wire logic       reqReady,
   input wire logic [2:0] reqOp,
   input wire logic       rspValid,
   input wire logic       rspFail,
   input wire logic       flCeN,
   input wire logic       flWeN,
   input wire logic       flOeN,
   input wire logic       flDqOe,
   input wire logic       flOeHv
);
   // ****
   // helper counts
   // ****
   int weLow;
   int hvLead;
   int opCyc;
   always_ff @(posedge clk_sys) begin
      weLow <= flWeN ? 0 : weLow + 1;
      hvLead <= !flOeHv ? 0 : flWeN ? hvLead + 1 : hvLead;
      opCyc <= (reqValid && reqReady) ? 0 : opCyc + 1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_take;
      reqValid && reqReady;
   endsequence
   sequence s_read;
      reqValid && reqReady && reqOp == `FAPES_OP_READ;
   endsequence
   sequence s_wrise;
      $rose(flWeN) && flOeHv;
   endsequence
   chk_rsp_pulse: assert property (rspValid |=> !rspValid)
      else $error("response longer than one cycle");
   chk_ready_back: assert property (rspValid |-> reqReady)
      else $error("not ready after response");
   chk_take_busy: assert property (s_take |=> !reqReady [*3])
      else $error("ready right after take");
   chk_read_lat: assert property (s_read |-> ##[5:7] rspValid)
      else $error("read answer late");
   chk_rd_nodrv: assert property (!flOeN && !flCeN |-> !flDqOe)
      else $error("host drives data during read");
   chk_prot_width: assert property (s_wrise |-> weLow >= PROT_CYC)
      else $error("protect pulse short");
   chk_oe_lead: assert property
      ($fell(flWeN) && flOeHv |-> hvLead >= OE_CYC)
      else $error("output enable lead short");
   chk_fail_late: assert property (rspValid && rspFail |-> opCyc >= PROG_CYC)
      else $error("timeout too early");
   chk_we_alone: assert property (!flWeN && !flOeHv |-> flOeN)
      else $error("write and read strobes together");
endmodule // fapes_host_asserts

bind fapes_host fapes_host_asserts #(
   .PROG_CYC(PROG_CYC), .PROT_CYC(PROT_CYC), .OE_CYC(OE_CYC)
) u_chk (
   .clk_sys(clk_sys), .nrst(nrst), .reqValid(reqValid),
   .reqReady(reqReady), .reqOp(reqOp), .rspValid(rspValid),
   .rspFail(rspFail), .flCeN(flCeN), .flWeN(flWeN),
   .flOeN(flOeN), .flDqOe(flDqOe), .flOeHv(flOeHv)
);

// >>> sim/fapes_flash_model.sv
/* behavioural flash device on the host pins.
 assumes: host strobes move on clk_sys edges. */
`timescale 1ns/100ps
module fapes_flash_model #(
   parameter PT   = 20,
   parameter ET   = 100,
   parameter LOAD = 50,
   parameter PROT = 200,
   parameter UNP  = 400,
   parameter OEL  = 80
) (
   input  wire logic        clk_sys,
   input  wire logic        slow,
   input  wire logic        stuck,
   input  wire logic [18:0] flAddr,
   input  wire logic [7:0]  flDqOut,
   input  wire logic        flDqOe,
   input  wire logic        flCeN,
   input  wire logic        flWeN,
   input  wire logic        flOeN,
   input  wire logic        flOeHv,
   input  wire logic        flA9Hv,
   output logic      [7:0]  flDqIn,
   output int               viol = 0
);
   // ****
   // array, status and commands
   // ****
   logic [7:0]  mem [int];
   logic [63:0] sm = 64'h0;
   logic [7:0]  pd = 8'h0, aq, dD = 8'h0, lastQ = 8'h0;
   logic [18:0] aD = 19'h0;
   logic        weD = 1, oeD = 1, tog = 0, prot = 0, idm = 0;
   int          st = 0, er = 0, bCnt = 0, ldCnt = 0, wLow = 0, hvCnt = 0;
   wire         bsy = ldCnt > 0 || bCnt > 0;
   wire         hv = flOeHv & flA9Hv;
   always @* begin
      if (bsy) aq = {er == 1 ? ~pd[7] : 1'h0, tog, pd[5:0]};
      else if (idm && flAddr[1]) aq = {7'h0, prot};
      else aq = mem.exists(flAddr) ? mem[flAddr] : 8'hff;
      flDqIn = flDqOe ? flDqOut : (!flCeN && !flOeN) ? aq : ~lastQ;
   end
   always @(posedge clk_sys) begin
      if (flOeN && !oeD && bsy) tog = ~tog;
      if (flWeN && !weD && hv) begin
         if (hvCnt < OEL) viol++;
         if (wLow >= UNP) prot = 0;
         else if (wLow >= PROT) prot = 1;
         else viol++;
      end else if (flWeN && !weD) begin
         if (ldCnt > 0 && dD == 8'h30) sm[aD[18:13]] = 1;
         else if (!bsy) begin
            if (dD == 8'hf0) idm = 0;
            case (st)
               0: st = dD == 8'haa;
               1: st = dD == 8'h55 ? 2 : 0;
               2: begin
                  idm |= dD == 8'h90;
                  st = dD == 8'ha0 ? 6 : dD == 8'h80 ? 3 : 0;
               end
               3: st = dD == 8'haa ? 4 : 0;
               4: st = dD == 8'h55 ? 5 : 0;
               5: begin
                  er = dD == 8'h10 ? 3 : dD == 8'h30 ? 2 : 0;
                  sm = 64'h0;
                  sm[aD[18:13]] = 1;
                  ldCnt = er == 2 ? LOAD : 0;
                  bCnt = er ? (slow ? 5 * ET : ET) : 0;
                  st = 0;
               end
               default: begin
                  mem[aD] = dD;
                  pd = dD;
                  er = 1;
                  bCnt = slow ? 7 * PT : PT;
                  st = 0;
               end
            endcase
         end
      end
      if (ldCnt > 0) ldCnt--;
      else if (bCnt > 0 && !stuck && --bCnt == 0)
         foreach (mem[k])
            if (er == 3 || (er == 2 && sm[k[18:13]])) mem[k] = 8'hff;
      wLow = flWeN ? 0 : wLow + 1;
      hvCnt = !hv ? 0 : flWeN ? hvCnt + 1 : hvCnt;
      weD = flWeN;
      oeD = flOeN;
      aD = flAddr;
      dD = flDqOut;
      if (!flCeN && !flOeN) lastQ = aq;
   end
endmodule // fapes_flash_model

// >>> sim/fapes_host_tb_top.sv
/* self-checking bench for the flash host controller.
 assumes: flash model on the pins, shortened timeouts. */
`timescale 1ns/100ps
`include "fapes_defines.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   error_cnt++; $display("FAIL %s exp %h got %h", n, e, g); end end
module fapes_host_tb_top;
   // ****
   // stimulus and checking
   // ****
   logic        clk_sys = 0, nrst = 0, reqValid = 0, extraValid = 0;
   logic        slow = 0, stuck = 0;
   logic [2:0]  reqOp = 0;
   logic [18:0] reqAddr = 0;
   logic [7:0]  reqData = 0, d;
   logic [5:0]  extraSector = 0;
   wire         reqReady, rspValid, rspFail, protectFlag, flDqOe;
   wire         flCeN, flWeN, flOeN, flOeHv, flA9Hv;
   wire  [7:0]  rspData, flDqOut, flDqIn;
   wire  [18:0] flAddr;
   int          error_cnt = 0, checks_done = 0, cyc = 0, viol, i;
   logic [9:0]  exp_q [$], e;
   logic [31:0] rs = 32'h4a;
   always #25 clk_sys = ~clk_sys;
   fapes_host #(.PROG_CYC(150), .SECT_CYC(600), .CHIP_CYC(800),
      .LOAD_CYC(50), .UNPROT_CYC(400)) DUT (
      .clk_sys(clk_sys), .nrst(nrst), .reqValid(reqValid),
      .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
      .reqData(reqData), .extraSector(extraSector),
      .extraValid(extraValid), .rspValid(rspValid), .rspFail(rspFail),
      .rspData(rspData), .protectFlag(protectFlag), .flAddr(flAddr),
      .flDqOut(flDqOut), .flDqOe(flDqOe), .flDqIn(flDqIn),
      .flCeN(flCeN), .flWeN(flWeN), .flOeN(flOeN), .flOeHv(flOeHv),
      .flA9Hv(flA9Hv));
   fapes_flash_model u_flash (
      .clk_sys(clk_sys), .slow(slow), .stuck(stuck), .flAddr(flAddr),
      .flDqOut(flDqOut), .flDqOe(flDqOe), .flCeN(flCeN), .flWeN(flWeN),
      .flOeN(flOeN), .flOeHv(flOeHv), .flA9Hv(flA9Hv),
      .flDqIn(flDqIn), .viol(viol));
   function automatic [31:0] xs(input [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic op(input [2:0] o, input [18:0] a, input [7:0] dt,
                     input [9:0] ex);
      int n;
      exp_q.push_back(ex);
      @(posedge clk_sys);
      #1;
      reqValid = 1;
      reqOp = o;
      reqAddr = a;
      reqData = dt;
      for (n = 0; n < 99 && reqReady !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      @(posedge clk_sys);
      #1;
      reqValid = 0;
      for (n = 0; n < 9999 && exp_q.size() > 0; n++) @(posedge clk_sys);
      #1;
   endtask
   always @(posedge clk_sys) if (rspValid === 1'b1) begin
      if (exp_q.size() == 0) `CHK("spare answer", 1'b0, 1'b1)
      else begin
         e = exp_q.pop_front();
         `CHK("rspFail", e[8], rspFail)
         if (e[9]) `CHK("rspData", e[7:0], rspData)
      end
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc >= 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      #1 nrst = 1;
      @(posedge clk_sys);
      #1;
      `CHK("idle pins", 5'h1e, {flCeN, flWeN, flOeN, reqReady, flDqOe})
      for (i = 0; i < 6; i++) begin
         rs = xs(rs);
         slow = rs[0];
         d = rs[15:8];
         op(`FAPES_OP_PROG, rs[31:13], d, 10'h0);
         op(`FAPES_OP_READ, rs[31:13], 8'h0, {2'b10, d});
      end
      $display("test program done");
      stuck = 1;
      op(`FAPES_OP_PROG, 19'h100, 8'h5a, 10'h100);
      stuck = 0;
      repeat (200) @(posedge clk_sys);
      $display("test timeout done");
      for (i = 0; i < 3; i++)
         op(`FAPES_OP_PROG, {6'(5 + 4 * i), 13'h5}, 8'h3c, 10'h0);
      slow = 1;
      extraSector = 6'h9;
      extraValid = 1;
      op(`FAPES_OP_SECT, {6'h5, 13'h0}, 8'h0, 10'h0);
      extraValid = 0;
      for (i = 0; i < 3; i++) op(`FAPES_OP_READ, {6'(5 + 4 * i), 13'h5}, 8'h0,
         {2'b10, i == 2 ? 8'h3c : 8'hff});
      $display("test sector erase done");
      op(`FAPES_OP_CHIP, 19'h0, 8'h0, 10'h0);
      op(`FAPES_OP_READ, {6'hd, 13'h5}, 8'h0, 10'h2ff);
      $display("test chip erase done");
      op(`FAPES_OP_PROT, 19'h0, 8'h0, 10'h0);
      op(`FAPES_OP_IDRD, 19'h0, 8'h0, 10'h201);
      `CHK("protectFlag", 1'b1, protectFlag)
      op(`FAPES_OP_UNPROT, 19'h0, 8'h0, 10'h0);
      op(`FAPES_OP_IDRD, 19'h0, 8'h0, 10'h200);
      `CHK("protectFlag", 1'b0, protectFlag)
      `CHK("pin timing", 0, viol)
      `CHK("answers left", 0, exp_q.size())
      $display("test protect done");
      complete_run();
   end
endmodule // fapes_host_tb_top
